//--- hw/cfg_reg_pkg.sv
package cfg_reg_pkg;

   // device address byte: type code in [7:4], straps in [3:1], direction in [0]
   localparam logic [3:0] DEV_TYPE_CODE = 4'hB;
   localparam int DEV_TYPE_MSB = 7;
   localparam int DEV_TYPE_LSB = 4;
   localparam int DEV_STRAP_MSB = 3;
   localparam int DEV_STRAP_LSB = 1;
   localparam int DEV_DIR_BIT = 0;

   // significant word address bits, seen within the upper address byte
   localparam int WA_BIT15_POS = 7;
   localparam int WA_BIT11_POS = 3;
   localparam int WA_BIT10_POS = 2;
   localparam logic WA_BIT15_VAL = 1'b1;
   localparam logic WA_BIT11_VAL = 1'b1;
   localparam logic WA_BIT10_VAL = 1'b0;

   // config_high_byte field positions
   localparam int ECC_FLAG_POS = 7;
   localparam int MODE_SEL_POS = 1;
   localparam int LOCK_POS = 0;
   localparam logic [4:0] UNUSED_BITS_VAL = 5'h00;

   // confirmation byte, chosen by the lock value being written
   localparam logic [7:0] CONFIRM_LOCK = 8'h99;
   localparam logic [7:0] CONFIRM_OPEN = 8'h66;

   // a write holds exactly this many bytes after the word address
   localparam logic [2:0] WRITE_BYTE_COUNT = 3'h3;
   localparam logic [2:0] WRITE_BYTE_SAT = 3'h4;

   // reset values (factory defaults; power-on clears the correction flag)
   localparam logic ECC_FLAG_RST = 1'b0;
   localparam logic MODE_SEL_RST = 1'b0;
   localparam logic LOCK_RST = 1'b0;
   localparam logic [7:0] ZONE_GUARD_RST = 8'h00;

   // array address: 15 bits, each zone spans 4096 bytes
   localparam int ARRAY_ADDR_W = 15;
   localparam int ZONE_SEL_MSB = 14;
   localparam int ZONE_SEL_LSB = 12;

   // bit counter value meaning "start seen, first falling edge pending"
   localparam logic [3:0] BIT_CNT_PRE = 4'hF;
   localparam logic [3:0] BIT_CNT_ACK = 4'h8;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;

   typedef struct packed {
      logic ecc_used_flag;
      logic zone_protect_mode_sel;
      logic lock;
      logic [7:0] zone_write_guard_bits;
   } cfg_s;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_DEV,
      PH_WADDR_HI,
      PH_WADDR_LO,
      PH_WDATA,
      PH_READ,
      PH_SKIP
   } phase_e;

endpackage

//--- hw/array_guard.sv
`timescale 1ns/1ps

// array-side logic on the array clock: write gating and read-result reporting
module array_guard
(
   // clock and reset
   input wire logic array_clk,
   input wire logic rst_n,
   // protection settings from the register domain (quasi-static levels)
   input wire logic mode_lvl,
   input wire logic [7:0] zones_lvl,
   // write-protect pin
   input wire logic wp_pin,
   // array write check
   input wire logic [cfg_reg_pkg::ARRAY_ADDR_W-1:0] wr_addr,
   output logic wr_block,
   output logic sec_block,
   // array read completion
   input wire logic rd_done,
   input wire logic rd_ecc,
   output logic ecc_val,
   output logic ecc_tgl
);

   typedef struct packed {
      logic mode_s1;
      logic mode_s2;
      logic [7:0] zones_s1;
      logic [7:0] zones_s2;
      logic wp_s1;
      logic wp_s2;
      logic wr_block;
      logic sec_block;
      logic ecc_val;
      logic ecc_tgl;
   } guard_s;

   guard_s st_reg;
   guard_s st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.mode_s1 = mode_lvl;
      st_next.mode_s2 = st_reg.mode_s1;
      st_next.zones_s1 = zones_lvl;
      st_next.zones_s2 = st_reg.zones_s1;
      st_next.wp_s1 = wp_pin;
      st_next.wp_s2 = st_reg.wp_s1;
      if (st_reg.mode_s2)
      begin
         // enhanced mode: pin ignored, the zone bit of the addressed 4 KiB zone decides
         st_next.wr_block = st_reg.zones_s2[wr_addr[cfg_reg_pkg::ZONE_SEL_MSB:cfg_reg_pkg::ZONE_SEL_LSB]];
         st_next.sec_block = 1'b0;
      end
      else
      begin
         st_next.wr_block = st_reg.wp_s2;
         st_next.sec_block = st_reg.wp_s2;
      end
      // data is held until the next read, so it is stable when the toggle lands
      if (rd_done)
      begin
         st_next.ecc_val = rd_ecc;
         st_next.ecc_tgl = ~st_reg.ecc_tgl;
      end
   end

   always_ff @(posedge array_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign wr_block = st_reg.wr_block;
   assign sec_block = st_reg.sec_block;
   assign ecc_val = st_reg.ecc_val;
   assign ecc_tgl = st_reg.ecc_tgl;

endmodule

//--- hw/eeprom_config_register.sv
`timescale 1ns/1ps

module eeprom_config_register
(
   // system clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // two-wire bus pins (open drain, drive low only)
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address straps
   input wire logic strap_addr_bit2,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit0,
   // array side, on its own clock
   input wire logic array_clk,
   input wire logic wp_pin,
   input wire logic [cfg_reg_pkg::ARRAY_ADDR_W-1:0] arr_wr_addr,
   output logic arr_wr_block,
   output logic sec_wr_block,
   input wire logic arr_rd_done,
   input wire logic arr_rd_ecc
);

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic tgl_s1;
      logic tgl_s2;
      logic tgl_s3;
      logic ecc_s1;
      logic ecc_s2;
      cfg_reg_pkg::phase_e phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic sda_oe;
      logic sda_out;
      logic addr_ok;
      logic [7:0] wa_hi;
      logic [2:0] wcnt;
      logic [7:0] data_hi;
      logic [7:0] data_lo;
      logic [7:0] confirm;
      logic tx_active;
      logic tx_sel;
      logic host_nak;
      logic ecc_wait;
      cfg_reg_pkg::cfg_s cfg;
   } state_s;

   state_s st_reg;
   state_s st_next;

   logic guard_ecc_val;
   logic guard_ecc_tgl;

   array_guard u_guard
   (
      .array_clk(array_clk),
      .rst_n(rst_n),
      .mode_lvl(st_reg.cfg.zone_protect_mode_sel),
      .zones_lvl(st_reg.cfg.zone_write_guard_bits),
      .wp_pin(wp_pin),
      .wr_addr(arr_wr_addr),
      .wr_block(arr_wr_block),
      .sec_block(sec_wr_block),
      .rd_done(arr_rd_done),
      .rd_ecc(arr_rd_ecc),
      .ecc_val(guard_ecc_val),
      .ecc_tgl(guard_ecc_tgl)
   );

   // edges and bus conditions from synchronised samples only
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic dev_match;
   logic wa_match;
   logic confirm_ok;
   logic [7:0] tx_byte;

   assign scl_rise = st_reg.scl_s2 & ~st_reg.scl_s3;
   assign scl_fall = ~st_reg.scl_s2 & st_reg.scl_s3;
   assign start_seen = st_reg.scl_s2 & st_reg.scl_s3 & st_reg.sda_s3 & ~st_reg.sda_s2;
   assign stop_seen = st_reg.scl_s2 & st_reg.scl_s3 & ~st_reg.sda_s3 & st_reg.sda_s2;

   // shift holds the completed byte at the falling edge that ends bit 8
   assign dev_match = (st_reg.shift[cfg_reg_pkg::DEV_TYPE_MSB:cfg_reg_pkg::DEV_TYPE_LSB]
                       == cfg_reg_pkg::DEV_TYPE_CODE)
                      && (st_reg.shift[cfg_reg_pkg::DEV_STRAP_MSB:cfg_reg_pkg::DEV_STRAP_LSB]
                          == st_reg.strap_s2);

   // only three address bits are decoded; the low address byte is discarded
   assign wa_match = (st_reg.wa_hi[cfg_reg_pkg::WA_BIT15_POS] == cfg_reg_pkg::WA_BIT15_VAL)
                     && (st_reg.wa_hi[cfg_reg_pkg::WA_BIT11_POS] == cfg_reg_pkg::WA_BIT11_VAL)
                     && (st_reg.wa_hi[cfg_reg_pkg::WA_BIT10_POS] == cfg_reg_pkg::WA_BIT10_VAL);

   assign confirm_ok = st_reg.data_hi[cfg_reg_pkg::LOCK_POS]
                       ? (st_reg.confirm == cfg_reg_pkg::CONFIRM_LOCK)
                       : (st_reg.confirm == cfg_reg_pkg::CONFIRM_OPEN);

   // high byte first; bits 14-10 are constant zero
   assign tx_byte = st_reg.tx_sel ? st_reg.cfg.zone_write_guard_bits
                    : {st_reg.cfg.ecc_used_flag, cfg_reg_pkg::UNUSED_BITS_VAL,
                       st_reg.cfg.zone_protect_mode_sel, st_reg.cfg.lock};

   always_comb
   begin
      st_next = st_reg;

      // synchronisers: the first stage feeds only the second
      st_next.scl_s1 = scl_in;
      st_next.scl_s2 = st_reg.scl_s1;
      st_next.scl_s3 = st_reg.scl_s2;
      st_next.sda_s1 = sda_in;
      st_next.sda_s2 = st_reg.sda_s1;
      st_next.sda_s3 = st_reg.sda_s2;
      st_next.strap_s1 = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      st_next.strap_s2 = st_reg.strap_s1;
      st_next.tgl_s1 = guard_ecc_tgl;
      st_next.tgl_s2 = st_reg.tgl_s1;
      st_next.tgl_s3 = st_reg.tgl_s2;
      st_next.ecc_s1 = guard_ecc_val;
      st_next.ecc_s2 = st_reg.ecc_s1;

      // array read finished: flag set or cleared by that read's result; the result is taken
      // one cycle after the toggle edge, because result and toggle change on the same array
      // edge and their synchronisers may settle on different samples
      st_next.ecc_wait = (st_reg.tgl_s2 != st_reg.tgl_s3);
      if (st_reg.ecc_wait)
      begin
         st_next.cfg.ecc_used_flag = st_reg.ecc_s2;
      end

      if (stop_seen)
      begin
         // commit only a complete, confirmed, unlocked write
         if ((st_reg.phase == cfg_reg_pkg::PH_WDATA) && st_reg.addr_ok
             && (st_reg.wcnt == cfg_reg_pkg::WRITE_BYTE_COUNT)
             && confirm_ok
             && !st_reg.cfg.lock)
         begin
            st_next.cfg.zone_protect_mode_sel = st_reg.data_hi[cfg_reg_pkg::MODE_SEL_POS];
            st_next.cfg.lock = st_reg.data_hi[cfg_reg_pkg::LOCK_POS];
            st_next.cfg.zone_write_guard_bits = st_reg.data_lo;
         end
         // a stop drops the pointer, so a read must follow a repeated start
         st_next.phase = cfg_reg_pkg::PH_IDLE;
         st_next.addr_ok = 1'b0;
         st_next.sda_oe = 1'b0;
         st_next.tx_active = 1'b0;
         // leave no acknowledge or byte choice behind for the next command,
         // which may be a read of another kind
         st_next.host_nak = 1'b0;
         st_next.tx_sel = 1'b0;
      end
      else if (start_seen)
      begin
         // a repeated start abandons any pending write data but keeps the pointer
         st_next.phase = cfg_reg_pkg::PH_DEV;
         st_next.bit_cnt = cfg_reg_pkg::BIT_CNT_PRE;
         st_next.sda_oe = 1'b0;
         st_next.tx_active = 1'b0;
         st_next.host_nak = 1'b0;
      end
      else if (scl_rise)
      begin
         if ((st_reg.phase == cfg_reg_pkg::PH_READ) && st_reg.tx_active
             && (st_reg.bit_cnt < cfg_reg_pkg::BIT_CNT_ACK))
         begin
            // while sending, the shifter moves only on the falling edge; sampling the
            // line here as well would skip every other bit
            st_next.shift = st_reg.shift;
         end
         else if (st_reg.bit_cnt < cfg_reg_pkg::BIT_CNT_ACK)
         begin
            st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
         end
         else if (st_reg.bit_cnt == cfg_reg_pkg::BIT_CNT_ACK)
         begin
            st_next.host_nak = st_reg.sda_s2;
         end
      end
      else if (scl_fall)
      begin
         if (st_reg.bit_cnt == cfg_reg_pkg::BIT_CNT_PRE)
         begin
            st_next.bit_cnt = 4'h0;
         end
         else if (st_reg.bit_cnt == cfg_reg_pkg::BIT_CNT_LAST)
         begin
            st_next.bit_cnt = cfg_reg_pkg::BIT_CNT_ACK;
            st_next.sda_oe = 1'b0;
            case (st_reg.phase)
               cfg_reg_pkg::PH_DEV:
               begin
                  if (!dev_match)
                  begin
                     st_next.phase = cfg_reg_pkg::PH_SKIP;
                  end
                  else if (!st_reg.shift[cfg_reg_pkg::DEV_DIR_BIT])
                  begin
                     st_next.phase = cfg_reg_pkg::PH_WADDR_HI;
                     st_next.addr_ok = 1'b0;
                     st_next.wcnt = 3'h0;
                     st_next.sda_oe = 1'b1;
                  end
                  else if (st_reg.addr_ok)
                  begin
                     // read needs a pointer set by the dummy write just before
                     st_next.phase = cfg_reg_pkg::PH_READ;
                     st_next.tx_sel = 1'b0;
                     st_next.sda_oe = 1'b1;
                  end
                  else
                  begin
                     st_next.phase = cfg_reg_pkg::PH_SKIP;
                  end
               end
               cfg_reg_pkg::PH_WADDR_HI:
               begin
                  st_next.wa_hi = st_reg.shift;
                  st_next.phase = cfg_reg_pkg::PH_WADDR_LO;
                  st_next.sda_oe = 1'b1;
               end
               cfg_reg_pkg::PH_WADDR_LO:
               begin
                  st_next.addr_ok = wa_match;
                  st_next.phase = cfg_reg_pkg::PH_WDATA;
                  st_next.sda_oe = 1'b1;
               end
               cfg_reg_pkg::PH_WDATA:
               begin
                  // every byte is acknowledged, even when locked; extra bytes spoil the count
                  case (st_reg.wcnt)
                     3'h0: st_next.data_hi = st_reg.shift;
                     3'h1: st_next.data_lo = st_reg.shift;
                     3'h2: st_next.confirm = st_reg.shift;
                     default: st_next.confirm = st_reg.confirm;
                  endcase
                  if (st_reg.wcnt != cfg_reg_pkg::WRITE_BYTE_SAT)
                  begin
                     st_next.wcnt = st_reg.wcnt + 3'h1;
                  end
                  st_next.sda_oe = 1'b1;
               end
               default:
               begin
                  st_next.sda_oe = 1'b0;
               end
            endcase
         end
         else if (st_reg.bit_cnt == cfg_reg_pkg::BIT_CNT_ACK)
         begin
            st_next.bit_cnt = 4'h0;
            st_next.sda_oe = 1'b0;
            if (st_reg.phase == cfg_reg_pkg::PH_READ)
            begin
               if (!st_reg.tx_active || !st_reg.host_nak)
               begin
                  // alternate bytes for as long as the host acknowledges
                  st_next.shift = tx_byte;
                  st_next.sda_oe = ~tx_byte[7];
                  st_next.tx_sel = ~st_reg.tx_sel;
                  st_next.tx_active = 1'b1;
               end
               else
               begin
                  st_next.phase = cfg_reg_pkg::PH_SKIP;
               end
            end
         end
         else if (st_reg.bit_cnt < cfg_reg_pkg::BIT_CNT_LAST)
         begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            if ((st_reg.phase == cfg_reg_pkg::PH_READ) && st_reg.tx_active)
            begin
               st_next.shift = {st_reg.shift[6:0], 1'b0};
               st_next.sda_oe = ~st_reg.shift[6];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.scl_s1 <= 1'b1;
         st_reg.scl_s2 <= 1'b1;
         st_reg.scl_s3 <= 1'b1;
         st_reg.sda_s1 <= 1'b1;
         st_reg.sda_s2 <= 1'b1;
         st_reg.sda_s3 <= 1'b1;
         st_reg.phase <= cfg_reg_pkg::PH_IDLE;
         st_reg.cfg.ecc_used_flag <= cfg_reg_pkg::ECC_FLAG_RST;
         st_reg.cfg.zone_protect_mode_sel <= cfg_reg_pkg::MODE_SEL_RST;
         st_reg.cfg.lock <= cfg_reg_pkg::LOCK_RST;
         st_reg.cfg.zone_write_guard_bits <= cfg_reg_pkg::ZONE_GUARD_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sda_out = st_reg.sda_out;
   assign sda_oe = st_reg.sda_oe;

endmodule

//--- verification/eeprom_config_register_assertions.sv
`timescale 1ns/1ps
module eeprom_config_register_assertions
(
   // system clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus pins and straps
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic strap_addr_bit2,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit0,
   // array side
   input wire logic array_clk,
   input wire logic wp_pin,
   input wire logic [cfg_reg_pkg::ARRAY_ADDR_W-1:0] arr_wr_addr,
   input wire logic arr_wr_block,
   input wire logic sec_wr_block,
   input wire logic arr_rd_done,
   input wire logic arr_rd_ecc
);
   // cycles since the bus clock fell; saturates so a long low phase never wraps
   logic [3:0] since_fall_reg;
   logic scl_q_reg;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         since_fall_reg <= 4'hF;
         scl_q_reg <= 1'b1;
      end
      else
      begin
         scl_q_reg <= scl_in;
         if (scl_q_reg && !scl_in)
            since_fall_reg <= 4'h1;
         else if (since_fall_reg != 4'hF)
            since_fall_reg <= since_fall_reg + 4'h1;
      end
   end

   sequence scl_held_high;
      scl_in ##1 scl_in;
   endsequence

   sequence stop_seen;
      scl_in && $rose(sda_in);
   endsequence

   oe_pin_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n) !sda_out)
      else $error("data output not low");
   oe_stable_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      scl_held_high |-> $stable(sda_oe)) else $error("data enable moved while clock high");
   oe_after_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $changed(sda_oe) |-> since_fall_reg inside {[4'h2:4'h6]}) else $error("data enable moved late");
   oe_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(sda_oe) |-> sda_oe[*8]) else $error("data enable pulse too short");
   idle_after_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stop_seen |=> !sda_oe[*4]) else $error("bus driven after stop");
   sec_needs_wp_a: assert property (@(posedge array_clk) disable iff (!rst_n)
      $rose(sec_wr_block) |-> $past(wp_pin, 2)) else $error("security guard without pin");
   sec_all_blocked_a: assert property (@(posedge array_clk) disable iff (!rst_n)
      sec_wr_block |-> arr_wr_block) else $error("array open while pin guards all");
   wp_low_free_a: assert property (@(posedge array_clk) disable iff (!rst_n)
      !wp_pin[*3] |=> !sec_wr_block) else $error("security guarded with pin low");
endmodule

//--- verification/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
(
   // timing reference
   input wire logic clk,
   // bus wire level and host drives
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // clock-high time in clk cycles, one third of a bus bit period; the bench raises it to act as a slow host
   int half = 8;

   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task tick();
      repeat (half) @(negedge clk);
   endtask

   // works as start and as repeated start
   task start();
      sda_low = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b1;
      tick();
      scl = 1'b0;
      tick();
   endtask

   task stop();
      sda_low = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b0;
      tick();
   endtask

   task bit_xfer(input logic b, output logic r);
      sda_low = !b;
      tick();
      scl = 1'b1;
      tick();
      r = sda;
      scl = 1'b0;
      tick();
   endtask

   // last is the ninth bit sent: 1 releases the line, 0 acknowledges
   task byte_xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(d[i], b);
         r[i] = b;
      end
      bit_xfer(last, b);
      ack = !b;
   endtask

   task cfg_write(input logic [2:0] st, input logic [15:0] wa, input logic [31:0] d, input int n,
                  output logic ok);
      logic [7:0] r;
      logic a;
      ok = 1'b1;
      start();
      byte_xfer({cfg_reg_pkg::DEV_TYPE_CODE, st, 1'b0}, 1'b1, r, a);
      ok &= a;
      byte_xfer(wa[15:8], 1'b1, r, a);
      ok &= a;
      byte_xfer(wa[7:0], 1'b1, r, a);
      ok &= a;
      for (int k = 0; k < n; k++)
      begin
         byte_xfer(d[31 - 8 * k -: 8], 1'b1, r, a);
         ok &= a;
      end
      stop();
   endtask

   task cfg_read(input logic [2:0] st, input logic [15:0] wa, output logic [23:0] d, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      byte_xfer({cfg_reg_pkg::DEV_TYPE_CODE, st, 1'b0}, 1'b1, r, a0);
      byte_xfer(wa[15:8], 1'b1, r, a1);
      byte_xfer(wa[7:0], 1'b1, r, a2);
      start();
      byte_xfer({cfg_reg_pkg::DEV_TYPE_CODE, st, 1'b1}, 1'b1, r, a3);
      ok = a0 && a1 && a2 && a3;
      byte_xfer(8'hFF, 1'b0, d[23:16], a0);
      byte_xfer(8'hFF, 1'b0, d[15:8], a0);
      byte_xfer(8'hFF, 1'b1, d[7:0], a0);
      stop();
   endtask
endmodule

//--- verification/test_eeprom_config_register.sv
`timescale 1ns/1ps
module test_eeprom_config_register;
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [15:0] WA = 16'h8800;
   localparam logic [7:0] ZONES = 8'hA5;
   logic sys_clk = 1'b0;
   logic array_clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sda_low, sda_w, sda_out, sda_oe, arr_wr_block, sec_wr_block;
   logic wp_pin = 1'b1;
   logic [cfg_reg_pkg::ARRAY_ADDR_W-1:0] arr_wr_addr = '0;
   logic arr_rd_done = 1'b0;
   logic arr_rd_ecc = 1'b0;
   int fails = 0;
   int tests_run = 0;

   always #5 sys_clk = !sys_clk;
   always #6 array_clk = !array_clk;
   // open-drain wire with pull-up
   assign sda_w = !(sda_low || (sda_oe && !sda_out));

   eeprom_config_register u_dut (.sys_clk, .rst_n, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe,
      .strap_addr_bit2(STRAP[2]), .strap_addr_bit1(STRAP[1]), .strap_addr_bit0(STRAP[0]), .array_clk,
      .wp_pin, .arr_wr_addr, .arr_wr_block, .sec_wr_block, .arr_rd_done, .arr_rd_ecc);
   i2c_host_model u_host (.clk(sys_clk), .sda(sda_w), .scl, .sda_low);

   task check8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task check1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task report_and_stop();
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task read_expect(input logic [15:0] wa, input logic [15:0] exp);
      logic [23:0] d;
      logic ok;
      u_host.cfg_read(STRAP, wa, d, ok);
      check1(ok, 1'b1);
      check8(d[23:16], exp[15:8]);
      check8(d[15:8], exp[7:0]);
      check8(d[7:0], exp[15:8]);
   endtask

   // guard outputs settle three array clock edges after the inputs
   task guard_expect(input logic wp, input logic [14:0] a, input logic blk, input logic sec);
      @(negedge array_clk);
      wp_pin = wp;
      arr_wr_addr = a;
      repeat (4) @(negedge array_clk);
      check1(arr_wr_block, blk);
      check1(sec_wr_block, sec);
   endtask

   task rd_report(input logic e);
      @(negedge array_clk);
      arr_rd_done = 1'b1;
      arr_rd_ecc = e;
      @(negedge array_clk);
      arr_rd_done = 1'b0;
   endtask

   task test_defaults();
      read_expect(WA, 16'h0000);
      guard_expect(1'b1, 15'h7FFF, 1'b1, 1'b1);
      guard_expect(1'b0, 15'h0000, 1'b0, 1'b0);
   endtask

   task test_refused();
      logic [7:0] r;
      logic [23:0] d;
      logic a, ok;
      for (int i = 0; i < 3; i++)
      begin
         u_host.start();
         u_host.byte_xfer(i == 0 ? {4'hA, STRAP, 1'b0} : {4'hB, i == 1 ? ~STRAP : STRAP, 1'b1}, 1'b1, r, a);
         u_host.stop();
         check1(a, 1'b0);
      end
      u_host.cfg_read(STRAP, 16'h8C00, d, ok);
      check1(ok, 1'b0);
      u_host.cfg_write(STRAP, WA, 32'h020F9900, 3, ok);
      u_host.cfg_write(STRAP, WA, 32'h03FF6600, 3, ok);
      u_host.cfg_write(STRAP, WA, 32'h020F6600, 2, ok);
      u_host.cfg_write(STRAP, WA, 32'h020F6600, 4, ok);
      u_host.cfg_write(STRAP, 16'h8C00, 32'h020F6600, 3, ok);
      check1(ok, 1'b1);
      read_expect(WA, 16'h0000);
   endtask

   task test_zones();
      logic ok;
      u_host.cfg_write(STRAP, 16'hFB5C, {8'hFE, ZONES, 16'h6600}, 3, ok);
      check1(ok, 1'b1);
      read_expect(WA, {8'h02, ZONES});
      for (int n = 0; n < 8; n++)
      begin
         guard_expect(1'b1, {3'(n), 12'hFFF}, ZONES[n], 1'b0);
         guard_expect(1'b0, {3'(n), 12'h000}, ZONES[n], 1'b0);
      end
   endtask

   task test_ecc();
      u_host.half = 20;
      rd_report(1'b1);
      read_expect(WA, {8'h82, ZONES});
      read_expect(WA, {8'h82, ZONES});
      rd_report(1'b0);
      read_expect(WA, {8'h02, ZONES});
      u_host.half = 8;
   endtask

   task test_lock();
      logic ok;
      u_host.cfg_write(STRAP, WA, 32'h000F6600, 3, ok);
      read_expect(WA, 16'h000F);
      guard_expect(1'b1, 15'h4000, 1'b1, 1'b1);
      u_host.cfg_write(STRAP, WA, 32'h03339900, 3, ok);
      read_expect(WA, 16'h0333);
      u_host.cfg_write(STRAP, WA, 32'h00006600, 3, ok);
      check1(ok, 1'b1);
      read_expect(WA, 16'h0333);
      guard_expect(1'b1, 15'h1000, 1'b1, 1'b0);
      guard_expect(1'b1, 15'h2000, 1'b0, 1'b0);
   endtask

   initial
   begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      test_defaults();
      test_refused();
      test_zones();
      test_ecc();
      test_lock();
      report_and_stop();
   end
endmodule

bind eeprom_config_register eeprom_config_register_assertions u_chk (.sys_clk, .rst_n, .scl_in, .sda_in,
   .sda_out, .sda_oe, .strap_addr_bit2, .strap_addr_bit1, .strap_addr_bit0, .array_clk, .wp_pin,
   .arr_wr_addr, .arr_wr_block, .sec_wr_block, .arr_rd_done, .arr_rd_ecc);
